// [pkg/mskpc_pkg.sv]
// How it works
// [RL1] host writes zero to config bits 15-11, 8, 4, 3; device stores them as zero
// [RL2] raw receive: hunt frame sync, interrupt, then deliver successive 16-bit words
// [RL3] packet receive: interrupt on complete valid header, then decode payload per header
// [RL4] raw transmit: send word A 16 bits at a time; host does all formatting
// [RL5] packet transmit: bit sync, frame sync, header from config and word A bytes
// [RL6] host sets final flag after load request for unsized types; device then stops
// [RL7] config bits 7-5 select message type 1 to 5; other codes reserved
// [RL8] config bit 2 is a free user bit carried in header, reported on receive
// [RL9] config bits 1-0 pick scrambler seed: FFFF, seed one, seed two, none
// [RL10] receiver descrambles with header seed setting and reports that setting
// [RL11] word B used only for types 4 and 5, giving a four byte buffer
// [RL12] if no new data arrives, current buffer contents are resent continuously
// [RL13] current block always finishes before newly loaded buffer contents start
// [RL14] word B holds high info tone code in bits 15-12, low in 11-8
// [RL15] host loads tone codes into word B before enabling tone-set transmit
// [RL16] host loads address and size; device adds control byte and header checksum
// [RL17] device adds parity, interleaving, scrambling and payload checksum by itself
// [RL18] host writes the two transmit words in two separate bus transactions
// [RL19] tone frequency is bits 11-0 at 1 Hz per step; zero means no tone
package mskpc_pkg;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0]  ADDR_CONFIG       = 8'hC7;
  localparam logic [7:0]  ADDR_PROG         = 8'hC8;
  localparam logic [7:0]  ADDR_TX_A         = 8'hCA;
  localparam logic [7:0]  ADDR_TX_B         = 8'hCB;
  localparam logic [7:0]  ADDR_TONE         = 8'hCD;
  localparam logic [15:0] CFG_RESERVED_MASK = 16'hF918;
  localparam int          CFG_RAW_BIT       = 10;
  localparam int          CFG_FINAL_BIT     = 9;
  localparam int          CFG_USER_BIT      = 2;
  localparam logic [15:0] RESET_WORD        = 16'h0000;

  // ****************************************
  // message types, seeds, sync patterns
  // ****************************************
  localparam logic [2:0]  TYPE_HEAD_ONLY    = 3'h1;
  localparam logic [2:0]  TYPE_UNSIZED_RAW  = 3'h2;
  localparam logic [2:0]  TYPE_UNSIZED_FEC  = 3'h3;
  localparam logic [2:0]  TYPE_SIZED_CRC    = 3'h4;
  localparam logic [2:0]  TYPE_SIZED_ILV    = 3'h5;
  localparam logic [1:0]  SEED_SEL_STD      = 2'h0;
  localparam logic [1:0]  SEED_SEL_ONE      = 2'h1;
  localparam logic [1:0]  SEED_SEL_TWO      = 2'h2;
  localparam logic [15:0] SEED_STD          = 16'hFFFF;
  localparam logic [15:0] SEED_NONE         = 16'h0000;
  localparam logic [15:0] BIT_SYNC          = 16'hAAAA;
  localparam logic [15:0] FRAME_SYNC        = 16'h3B28;

  // ****************************************
  // bit counts
  // ****************************************
  localparam logic [4:0]  BUS_LAST_BIT      = 5'h17;
  localparam logic [5:0]  PRE_BITS          = 6'h20;
  localparam logic [5:0]  HEAD_BITS         = 6'h20;
  localparam logic [5:0]  WORD_BITS         = 6'h10;
  localparam logic [5:0]  FEC16_BITS        = 6'h18;
  localparam logic [5:0]  FEC32_BITS        = 6'h28;
  localparam logic [5:0]  PARITY_BITS       = 6'h08;
  localparam logic [5:0]  CKSUM_BITS        = 6'h10;

  typedef enum logic [5:0] {
    TX_IDLE  = 6'h01,
    TX_PRE   = 6'h02,
    TX_HEAD  = 6'h04,
    TX_DATA  = 6'h08,
    TX_CKSUM = 6'h10,
    TX_DONE  = 6'h20
  } mskpc_tx_e;

  typedef enum logic [3:0] {
    RX_HUNT  = 4'h1,
    RX_HEAD  = 4'h2,
    RX_DATA  = 4'h4,
    RX_CKSUM = 4'h8
  } mskpc_rx_e;

endpackage

// [hdl/mskpc_top.sv]
`timescale 1ns/1ps
module mskpc_top import mskpc_pkg::*; (
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CSN_I,
  input  wire logic        SCLK_I,
  input  wire logic        CDATA_I,
  input  wire logic [15:0] SEED_ONE_I,
  input  wire logic [15:0] SEED_TWO_I,
  input  wire logic        TX_EN_I,
  input  wire logic        TX_BIT_STB_I,
  output logic             TX_BIT_O,
  output logic             TX_ACTIVE_O,
  output logic             TX_LOAD_REQ_O,
  input  wire logic        RX_EN_I,
  input  wire logic        RX_BIT_I,
  input  wire logic        RX_BIT_STB_I,
  output logic             RX_IRQ_O,
  output logic [15:0]      RX_WORD_O,
  output logic             RX_WORD_VALID_O,
  output logic [7:0]       RX_ADDR_O,
  output logic [7:0]       RX_SIZE_O,
  output logic [2:0]       RX_TYPE_O,
  output logic             RX_USER_BIT_O,
  output logic [1:0]       RX_SEED_SEL_O,
  output logic             RX_END_O,
  output logic             RX_CRC_OK_O,
  output logic [11:0]      TONE_FREQ_O,
  output logic             TONE_ON_O,
  output logic [3:0]       TONE_SET_INFO_HIGH_O,
  output logic [3:0]       TONE_SET_INFO_LOW_O,
  output logic [15:0]      PROG_WORD_O,
  output logic             PROG_WRITE_O
);

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    logic        sclk_q;
    logic [22:0] bus_sh;
    logic [4:0]  bus_cnt;
    logic [15:0] cfg;
    logic [15:0] prog;
    logic        prog_wr;
    logic [15:0] tx_a;
    logic [15:0] tx_b;
    logic [15:0] tone;
    logic        fresh;
    mskpc_tx_e   tx_st;
    logic [39:0] tx_sh;
    logic [5:0]  tx_cnt;
    logic [5:0]  tx_par;
    logic [7:0]  tx_blocks;
    logic [15:0] tx_lfsr;
    logic [15:0] tx_sum;
    logic        tx_bit;
    logic        load_req;
    mskpc_rx_e   rx_st;
    logic [39:0] rx_sh;
    logic [5:0]  rx_cnt;
    logic [5:0]  rx_tot;
    logic        rx_raw;
    logic [7:0]  rx_blocks;
    logic [15:0] rx_lfsr;
    logic [15:0] rx_sum;
    logic [31:0] rx_hdr;
    logic [15:0] rx_word;
    logic        rx_word_v;
    logic [15:0] rx_pend;
    logic        rx_pend_v;
    logic        rx_irq;
    logic        rx_end;
    logic        rx_crc_ok;
  } mskpc_state_s;

  mskpc_state_s st;
  mskpc_state_s next_st;

  // ****************************************
  // helpers
  // ****************************************
  // one scrambler step; a zero seed stays zero, so "no scrambling" needs no special case
  function automatic logic [15:0] lfsr_step(input logic [15:0] l);
    return {l[0] ^ l[2] ^ l[3] ^ l[5], l[15:1]};
  endfunction

  function automatic logic [15:0] seed_of(input logic [1:0] sel, input logic [15:0] s1, input logic [15:0] s2);
    unique case (sel)
      SEED_SEL_STD: return SEED_STD;                                      // [RL9]
      SEED_SEL_ONE: return s1;                                            // [RL9]
      SEED_SEL_TWO: return s2;                                            // [RL9]
      default:      return SEED_NONE;                                     // [RL9]
    endcase
  endfunction

  // block length in bits, parity included
  function automatic logic [5:0] blk_bits(input logic [2:0] ty, input logic raw);
    if (raw || ty == TYPE_UNSIZED_RAW) begin
      return WORD_BITS;
    end else if (ty == TYPE_UNSIZED_FEC) begin
      return FEC16_BITS;
    end
    return FEC32_BITS;
  endfunction

  // 4 bytes by 8 bits transpose; spreads a burst over all four bytes
  function automatic logic [31:0] ilv(input logic [31:0] d);
    logic [31:0] o;
    o = 32'h0000_0000;
    for (int b = 0; b < 8; b++) begin
      for (int k = 0; k < 4; k++) begin
        o[b*4+k] = d[k*8+b];
      end
    end
    return o;
  endfunction

  function automatic logic [31:0] deilv(input logic [31:0] d);
    logic [31:0] o;
    o = 32'h0000_0000;
    for (int b = 0; b < 8; b++) begin
      for (int k = 0; k < 4; k++) begin
        o[k*8+b] = d[b*4+k];
      end
    end
    return o;
  endfunction

  function automatic logic [15:0] byte_sum(input logic [31:0] d);
    return {8'h00, d[31:24]} + {8'h00, d[23:16]} + {8'h00, d[15:8]} + {8'h00, d[7:0]};
  endfunction

  // ****************************************
  // combinational views of the state
  // ****************************************
  logic        bus_rise;
  logic [23:0] bus_word;
  logic [2:0]  tx_type;
  logic        tx_raw;
  logic        tx_sized;
  logic [7:0]  tx_par_byte;
  logic [39:0] tx_block;
  logic [7:0]  head_ck;
  logic        rx_bit;
  logic [39:0] rx_shn;
  logic [31:0] rx_data;
  logic [2:0]  rx_ty;
  logic [7:0]  rx_ck;

  always_comb begin
    bus_rise    = SCLK_I & ~st.sclk_q;
    bus_word    = {st.bus_sh, CDATA_I};
    tx_type     = st.cfg[7:5];                                            // [RL7]
    tx_raw      = st.cfg[CFG_RAW_BIT];
    tx_sized    = ~tx_raw && (tx_type == TYPE_SIZED_CRC || tx_type == TYPE_SIZED_ILV);
    tx_par_byte = st.tx_a[15:8] ^ st.tx_a[7:0] ^ st.tx_b[15:8] ^ st.tx_b[7:0];
    // word B joins the block for the sized types and for the reserved codes 0, 6 and 7
    if (tx_raw || tx_type == TYPE_UNSIZED_RAW) begin
      tx_block = {st.tx_a, 24'h000000};                                   // [RL4]
    end else if (tx_type == TYPE_UNSIZED_FEC) begin
      tx_block = {st.tx_a, st.tx_a[15:8] ^ st.tx_a[7:0], 16'h0000};       // [RL17]
    end else if (tx_type == TYPE_SIZED_ILV) begin
      tx_block = {ilv({st.tx_a, st.tx_b}), tx_par_byte};                  // [RL11] [RL17]
    end else begin
      tx_block = {st.tx_a, st.tx_b, tx_par_byte};                         // [RL11]
    end
    head_ck = st.tx_a[15:8] + st.tx_a[7:0] + st.cfg[7:0];                 // [RL16]
    rx_bit  = RX_BIT_I ^ (st.rx_st == RX_DATA && !st.rx_raw && st.rx_cnt > st.rx_tot - blk_bits(rx_ty, 1'b0)
              + (st.rx_tot == WORD_BITS ? 6'h00 : PARITY_BITS) - (st.rx_tot == WORD_BITS ? 6'h00 : PARITY_BITS)
              && st.rx_cnt > (st.rx_tot == WORD_BITS ? 6'h00 : PARITY_BITS) && st.rx_lfsr[0]); // [RL10]
    rx_shn  = {st.rx_sh[38:0], rx_bit};
    rx_ty   = st.rx_hdr[15:13];
    rx_ck   = rx_shn[31:24] + rx_shn[23:16] + rx_shn[15:8];
    if (st.rx_tot == FEC32_BITS) begin
      rx_data = (rx_ty == TYPE_SIZED_ILV) ? deilv(rx_shn[39:8]) : rx_shn[39:8];
    end else if (st.rx_tot == FEC16_BITS) begin
      rx_data = {rx_shn[23:8], 16'h0000};
    end else begin
      rx_data = {rx_shn[15:0], 16'h0000};
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st          = st;
    next_st.sclk_q   = SCLK_I;
    next_st.prog_wr  = 1'b0;
    next_st.load_req = 1'b0;
    next_st.rx_irq   = 1'b0;
    next_st.rx_end   = 1'b0;
    next_st.rx_word_v = 1'b0;

    // -- transmit --
    if (!TX_EN_I) begin
      next_st.tx_st = TX_IDLE;
    end else if (st.tx_st == TX_IDLE) begin
      next_st.tx_sum = 16'h0000;
      if (tx_raw) begin
        next_st.tx_st    = TX_DATA;                                       // [RL4]
        next_st.tx_sh    = tx_block;
        next_st.tx_cnt   = WORD_BITS;
        next_st.tx_par   = 6'h00;
        next_st.fresh    = 1'b0;
        next_st.load_req = 1'b1;
      end else begin
        next_st.tx_st  = TX_PRE;                                          // [RL5]
        next_st.tx_sh  = {BIT_SYNC, FRAME_SYNC, 8'h00};
        next_st.tx_cnt = PRE_BITS;
      end
    end else if (TX_BIT_STB_I && st.tx_st != TX_DONE) begin
      // scramble only the data part of a packet block, never parity or checksum
      next_st.tx_bit = st.tx_sh[39] ^ (st.tx_st == TX_DATA && !tx_raw && st.tx_cnt > st.tx_par
                       && st.tx_lfsr[0]);                                 // [RL17]
      if (st.tx_st == TX_DATA && !tx_raw && st.tx_cnt > st.tx_par) begin
        next_st.tx_lfsr = lfsr_step(st.tx_lfsr);
      end
      next_st.tx_sh  = {st.tx_sh[38:0], 1'b0};
      next_st.tx_cnt = st.tx_cnt - 6'h01;
      if (st.tx_cnt == 6'h01) begin
        // the segment on air ends here; only now may new buffer contents start
        unique case (st.tx_st)
          TX_PRE: begin
            next_st.tx_st     = TX_HEAD;
            next_st.tx_sh     = {st.tx_a, st.cfg[7:0], head_ck, 8'h00};   // [RL5] [RL16] [RL8]
            next_st.tx_cnt    = HEAD_BITS;
            next_st.tx_blocks = st.tx_a[7:0];
            next_st.tx_lfsr   = seed_of(st.cfg[1:0], SEED_ONE_I, SEED_TWO_I); // [RL9]
            next_st.fresh     = 1'b0;
            next_st.load_req  = 1'b1;
          end
          TX_HEAD, TX_DATA: begin
            if (st.tx_st == TX_HEAD && tx_type == TYPE_HEAD_ONLY) begin
              next_st.tx_st = TX_DONE;                                    // [RL7]
            end else if (st.tx_st == TX_DATA && !tx_sized && st.cfg[CFG_FINAL_BIT]) begin
              next_st.tx_st = TX_DONE;                                    // [RL6]
            end else if (tx_sized && st.tx_blocks == 8'h00) begin
              next_st.tx_st  = TX_CKSUM;                                  // [RL17]
              next_st.tx_sh  = {st.tx_sum, 24'h000000};
              next_st.tx_cnt = CKSUM_BITS;
            end else begin
              // unchanged buffer is simply sent again
              next_st.tx_st     = TX_DATA;                                // [RL12] [RL13]
              next_st.tx_sh     = tx_block;
              next_st.tx_cnt    = blk_bits(tx_type, tx_raw);
              next_st.tx_par    = (blk_bits(tx_type, tx_raw) == WORD_BITS) ? 6'h00 : PARITY_BITS;
              next_st.tx_blocks = st.tx_blocks - (tx_sized ? 8'h01 : 8'h00);
              next_st.tx_sum    = st.tx_sum + byte_sum({st.tx_a, st.tx_b});
              next_st.fresh     = 1'b0;
              next_st.load_req  = 1'b1;
            end
          end
          TX_CKSUM: next_st.tx_st = TX_DONE;
          default:  next_st.tx_st = TX_IDLE;
        endcase
      end
    end

    // -- control bus: 8 address bits then 16 data bits, msb first --
    if (CSN_I) begin
      next_st.bus_cnt = 5'h00;
    end else if (bus_rise) begin
      next_st.bus_sh  = bus_word[22:0];
      next_st.bus_cnt = st.bus_cnt + 5'h01;
      if (st.bus_cnt == BUS_LAST_BIT) begin
        next_st.bus_cnt = 5'h00;
        unique case (bus_word[23:16])
          ADDR_CONFIG: next_st.cfg  = bus_word[15:0] & ~CFG_RESERVED_MASK; // [RL1]
          ADDR_PROG: begin
            next_st.prog    = bus_word[15:0];
            next_st.prog_wr = 1'b1;
          end
          ADDR_TX_A: begin
            next_st.tx_a  = bus_word[15:0];                               // [RL18]
            next_st.fresh = 1'b1;                                         // a write beats a take
          end
          ADDR_TX_B:   next_st.tx_b = bus_word[15:0];                     // [RL14] [RL15]
          ADDR_TONE:   next_st.tone = bus_word[15:0];                     // [RL19]
          default:     next_st.bus_cnt = 5'h00;                           // unmapped: ignored
        endcase
      end
    end

    // -- receive --
    if (st.rx_pend_v) begin
      next_st.rx_word   = st.rx_pend;
      next_st.rx_word_v = 1'b1;
      next_st.rx_pend_v = 1'b0;
    end
    if (!RX_EN_I) begin
      next_st.rx_st = RX_HUNT;
    end else if (RX_BIT_STB_I) begin
      next_st.rx_sh  = rx_shn;
      next_st.rx_cnt = st.rx_cnt - 6'h01;
      if (st.rx_st == RX_DATA && !st.rx_raw && st.rx_cnt > st.rx_tot - blk_bits(rx_ty, 1'b0)
          + (st.rx_tot == WORD_BITS ? 6'h00 : PARITY_BITS) - (st.rx_tot == WORD_BITS ? 6'h00 : PARITY_BITS)
          && st.rx_cnt > (st.rx_tot == WORD_BITS ? 6'h00 : PARITY_BITS)) begin
        next_st.rx_lfsr = lfsr_step(st.rx_lfsr);                          // [RL10]
      end
      unique case (st.rx_st)
        RX_HUNT: begin
          if (rx_shn[15:0] == FRAME_SYNC) begin
            next_st.rx_raw = st.cfg[CFG_RAW_BIT];
            if (st.cfg[CFG_RAW_BIT]) begin
              next_st.rx_st  = RX_DATA;                                   // [RL2]
              next_st.rx_irq = 1'b1;                                      // [RL2]
              next_st.rx_cnt = WORD_BITS;
              next_st.rx_tot = WORD_BITS;
            end else begin
              next_st.rx_st  = RX_HEAD;                                   // [RL3]
              next_st.rx_cnt = HEAD_BITS;
            end
          end
        end
        RX_HEAD: begin
          if (st.rx_cnt == 6'h01) begin
            // a bad checksum or reserved type is dropped without an interrupt
            if (rx_ck != rx_shn[7:0] || rx_shn[15:13] < TYPE_HEAD_ONLY || rx_shn[15:13] > TYPE_SIZED_ILV) begin
              next_st.rx_st = RX_HUNT;
            end else begin
              next_st.rx_irq    = 1'b1;                                   // [RL3]
              next_st.rx_hdr    = rx_shn[31:0];                           // [RL8] [RL10]
              next_st.rx_lfsr   = seed_of(rx_shn[9:8], SEED_ONE_I, SEED_TWO_I); // [RL10]
              next_st.rx_sum    = 16'h0000;
              next_st.rx_blocks = rx_shn[23:16];
              next_st.rx_tot    = blk_bits(rx_shn[15:13], 1'b0);
              next_st.rx_cnt    = blk_bits(rx_shn[15:13], 1'b0);
              next_st.rx_st     = RX_DATA;
              if (rx_shn[15:13] == TYPE_HEAD_ONLY) begin
                next_st.rx_st  = RX_HUNT;
                next_st.rx_end = 1'b1;
              end else if (rx_shn[15:13] >= TYPE_SIZED_CRC && rx_shn[23:16] == 8'h00) begin
                next_st.rx_st  = RX_CKSUM;
                next_st.rx_cnt = CKSUM_BITS;
              end
            end
          end
        end
        RX_DATA: begin
          if (st.rx_cnt == 6'h01) begin
            next_st.rx_word   = rx_data[31:16];                           // [RL2] [RL3]
            next_st.rx_word_v = 1'b1;
            next_st.rx_cnt    = st.rx_tot;
            if (st.rx_tot == FEC32_BITS) begin
              next_st.rx_pend   = rx_data[15:0];
              next_st.rx_pend_v = 1'b1;
              next_st.rx_sum    = st.rx_sum + byte_sum(rx_data);
              next_st.rx_blocks = st.rx_blocks - 8'h01;
              if (st.rx_blocks == 8'h01) begin
                next_st.rx_st  = RX_CKSUM;
                next_st.rx_cnt = CKSUM_BITS;
              end
            end
          end
        end
        RX_CKSUM: begin
          if (st.rx_cnt == 6'h01) begin
            next_st.rx_crc_ok = (rx_shn[15:0] == st.rx_sum);              // [RL3]
            next_st.rx_end    = 1'b1;
            next_st.rx_st     = RX_HUNT;
          end
        end
        default: next_st.rx_st = RX_HUNT;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      st       <= '0;
      st.tx_st <= TX_IDLE;
      st.rx_st <= RX_HUNT;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state record
  assign TX_BIT_O             = st.tx_bit;
  assign TX_ACTIVE_O          = (st.tx_st != TX_IDLE) && (st.tx_st != TX_DONE);
  assign TX_LOAD_REQ_O        = st.load_req;
  assign RX_IRQ_O             = st.rx_irq;
  assign RX_WORD_O            = st.rx_word;
  assign RX_WORD_VALID_O      = st.rx_word_v;
  assign RX_ADDR_O            = st.rx_hdr[31:24];
  assign RX_SIZE_O            = st.rx_hdr[23:16];
  assign RX_TYPE_O            = st.rx_hdr[15:13];
  assign RX_USER_BIT_O        = st.rx_hdr[8+CFG_USER_BIT];                // [RL8]
  assign RX_SEED_SEL_O        = st.rx_hdr[9:8];                           // [RL10]
  assign RX_END_O             = st.rx_end;
  assign RX_CRC_OK_O          = st.rx_crc_ok;
  assign TONE_FREQ_O          = st.tone[11:0];                            // [RL19]
  assign TONE_ON_O            = |st.tone[11:0];                           // [RL19]
  assign TONE_SET_INFO_HIGH_O = st.tx_b[15:12];                           // [RL14]
  assign TONE_SET_INFO_LOW_O  = st.tx_b[11:8];                            // [RL14]
  assign PROG_WORD_O          = st.prog;
  assign PROG_WRITE_O         = st.prog_wr;

endmodule

// [test/mskpc_top_properties.sv]
`timescale 1ns/1ps
module mskpc_top_properties (
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        CSN_I,
  input wire logic        TX_EN_I,
  input wire logic        TX_BIT_STB_I,
  input wire logic        TX_BIT_O,
  input wire logic        TX_ACTIVE_O,
  input wire logic        TX_LOAD_REQ_O,
  input wire logic        RX_BIT_STB_I,
  input wire logic        RX_IRQ_O,
  input wire logic        RX_WORD_VALID_O,
  input wire logic [11:0] TONE_FREQ_O,
  input wire logic        TONE_ON_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // ****************************************
  // transmit
  // ****************************************
  // a sent bit moves only on its strobe while a frame runs
  a_bit_holds: assert property (!TX_BIT_STB_I && TX_ACTIVE_O ##1 TX_ACTIVE_O |-> $stable(TX_BIT_O))
    else $error("tx bit moved off strobe");
  a_load_pulse: assert property (TX_LOAD_REQ_O |-> TX_ACTIVE_O ##1 !TX_LOAD_REQ_O)
    else $error("load request not a pulse");
  a_tx_start: assert property ($rose(TX_ACTIVE_O) |-> $past(TX_EN_I))
    else $error("tx started unasked");
  // dropping enable must idle at once, else a stale block leaks out
  a_tx_abort: assert property (!TX_EN_I |=> !TX_ACTIVE_O)
    else $error("tx kept running");
  // ****************************************
  // receive and tone
  // ****************************************
  a_irq_cause: assert property (RX_IRQ_O |-> $past(RX_BIT_STB_I) ##1 !RX_IRQ_O)
    else $error("irq without last bit");
  a_word_cause: assert property (RX_WORD_VALID_O |-> $past(RX_BIT_STB_I) || $past(RX_WORD_VALID_O))
    else $error("word without bits");
  a_tone_on: assert property (TONE_ON_O == (TONE_FREQ_O != 12'h000))
    else $error("tone flag wrong");
  // only a finished bus write may retune
  a_tone_write: assert property ($changed(TONE_FREQ_O) |-> !$past(CSN_I))
    else $error("tone moved without write");
  c_header: cover property (RX_IRQ_O);
  c_word: cover property (RX_WORD_VALID_O);
  c_load: cover property (TX_LOAD_REQ_O ##1 TX_ACTIVE_O);
endmodule

bind mskpc_top mskpc_top_properties u_mskpc_top_properties (.*);

// [test/mskpc_radio_model.sv]
`timescale 1ns/1ps
// ****************************************
// far modem: bit timing and looped channel
// ****************************************
module mskpc_radio_model #(
  parameter int DIV = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tx_bit_i,
  output logic      tx_stb_o,
  output logic      rx_stb_o,
  output logic      rx_bit_o
);
  int         cnt = 0;
  logic [1:0] dly = 2'h0;
  // one bit every DIV cycles; receive lags two so the sent bit has settled
  always @(posedge clk_i) begin
    cnt <= (rst_i || cnt == DIV - 1) ? 0 : cnt + 1;
    dly <= {dly[0], tx_stb_o};
  end
  assign tx_stb_o = !rst_i && cnt == DIV - 1;
  assign rx_stb_o = dly[1];
  // off the strobe the line shows junk, not the held bit
  assign rx_bit_o = rx_stb_o ? tx_bit_i : ~tx_bit_i;
endmodule

// [test/mskpc_top_test.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module mskpc_top_test import mskpc_pkg::*;;
  logic        clk = 0, rst = 1, csn = 1, sclk = 0, cdat = 0, txen = 0, rxen = 0, raw = 0;
  logic        txb, act, ld, tstb, rstb, rbit, irq, wv, ub, ton, rend, cok;
  logic [31:0] r;
  logic [21:0] eh;
  logic [15:0] s1, s2, word, w, ew;
  logic [11:0] tf;
  logic [7:0]  ad, sz;
  logic [3:0]  th, tl;
  logic [2:0]  ty;
  logic [1:0]  ss;
  logic [21:0] hq[$];
  logic [15:0] wq[$];
  int          seed = 91, err_total = 0, compares = 0, cyc = 0, ends = 0, i, k;

  mskpc_top u_mskpc_top (.CLK_I(clk), .RESET_I(rst), .CSN_I(csn), .SCLK_I(sclk), .CDATA_I(cdat),
    .SEED_ONE_I(s1), .SEED_TWO_I(s2), .TX_EN_I(txen), .TX_BIT_STB_I(tstb), .TX_BIT_O(txb),
    .TX_ACTIVE_O(act), .TX_LOAD_REQ_O(ld), .RX_EN_I(rxen), .RX_BIT_I(rbit), .RX_BIT_STB_I(rstb),
    .RX_IRQ_O(irq), .RX_WORD_O(word), .RX_WORD_VALID_O(wv), .RX_ADDR_O(ad), .RX_SIZE_O(sz),
    .RX_TYPE_O(ty), .RX_USER_BIT_O(ub), .RX_SEED_SEL_O(ss), .RX_END_O(rend), .RX_CRC_OK_O(cok),
    .TONE_FREQ_O(tf), .TONE_ON_O(ton), .TONE_SET_INFO_HIGH_O(th), .TONE_SET_INFO_LOW_O(tl),
    .PROG_WORD_O(), .PROG_WRITE_O());
  mskpc_radio_model u_mskpc_radio_model (.clk_i(clk), .rst_i(rst), .tx_bit_i(txb),
    .tx_stb_o(tstb), .rx_stb_o(rstb), .rx_bit_o(rbit));

  always #2.5 clk = ~clk;

  task automatic stop_test;
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one 24-bit write, address then data, msb first; each word its own transaction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [23:0] v;
    v = {a, d};
    csn = 0;
    for (int b = 23; b >= 0; b--) begin
      @(negedge clk) sclk = 0;
      cdat = v[b];
      @(negedge clk) sclk = 1;
    end
    @(negedge clk) sclk = 0;
    csn = 1;
    repeat (2) @(negedge clk);
  endtask

  // hang guard: the whole run needs only a few thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test;
    end
  end

  // results pop the oldest note; an irq with no note pending is a mismatch
  always @(posedge clk) begin
    if (irq && !raw) begin
      eh = hq.size() ? hq.pop_front() : 'x;
      `CHK({ad, sz, ty, ub, ss}, eh)
    end
    if (rend) ends++;
    if (wv && wq.size()) begin
      ew = wq.pop_front();
      `CHK(word, ew)
    end
  end

  initial begin
    s1 = $random(seed);
    s2 = $random(seed);
    repeat (12) @(negedge clk);
    rst = 0;
    `CHK({act, ton, tf, th, tl}, 22'h000000)
    r = $random(seed);
    wr(ADDR_TX_B, {r[15:8], 8'h00});  // codes go in before any tone set is sent
    `CHK({th, tl}, r[15:8])
    for (i = 0; i < 2; i++) begin
      w = i ? {4'h0, r[27:16]} : 16'h0000;
      wr(ADDR_TONE, w);
      `CHK({ton, tf}, {|w, w[11:0]})
    end
    wr(8'hC9, ~w);  // unmapped: nothing may move
    `CHK({ton, tf, th, tl}, {|w, w[11:0], r[15:8]})
    // every type code plus a reserved one (6), every seed choice, random user bit
    for (i = 1; i < 7; i++) begin
      r = $random(seed);
      wr(ADDR_CONFIG, {8'h00, i[2:0], 2'h0, r[0], i[1:0]});  // reserved and final bits zero
      wr(ADDR_TX_A, {r[31:24], 8'h01});  // address and size first, one block
      wr(ADDR_TX_B, r[15:0]);
      if (i < 6) hq.push_back({r[31:24], 8'h01, i[2:0], r[0], i[1:0]});
      if (i > 1 && i < 6) wq.push_back({r[31:24], 8'h01});  // no reload: word A goes again
      if (i > 3 && i < 6) wq.push_back(r[15:0]);  // sized types carry word B too
      rxen = 1;
      txen = 1;
      repeat (560) @(negedge clk);  // 64 bit periods of preamble and header, then 56 of payload
      txen = 0;
      rxen = 0;
      `CHK(hq.size(), 0)
      `CHK(wq.size(), 0)
      `CHK(cok, i > 3)
      @(negedge clk);
    end
    `CHK(ends, 3)
    raw = 1;
    wr(ADDR_CONFIG, 16'h0403);  // raw words, scrambler off
    wr(ADDR_TX_A, FRAME_SYNC);  // host makes its own sync word
    txen = 1;
    rxen = 1;
    for (i = 0; i < 2; i++) begin
      for (k = 0; k < 200 && !ld; k++) @(negedge clk);
      w = $random(seed);
      wr(ADDR_TX_A, w);  // lands while the previous block still goes out
      wq.push_back(w);
    end
    wq.push_back(w);  // no reload, so the last word repeats
    for (k = 0; k < 1000 && wq.size(); k++) @(negedge clk);
    `CHK(wq.size(), 0)
    wr(ADDR_CONFIG, 16'h0603);  // last data: the block on air ends the frame
    repeat (70) @(negedge clk);
    `CHK(act, 1'b0)
    stop_test;
  end
endmodule
